// file: rtl/itc_pkg.sv
// Package of register offsets, field positions, reset values and encodings for the interval timer.
package itc_pkg;
  localparam logic [7:0] ITC_OFF_CONTROL = 8'h00;
  localparam logic [7:0] ITC_OFF_DIVIDER = 8'h04;
  localparam logic [7:0] ITC_OFF_MODE = 8'h08;
  localparam logic [7:0] ITC_OFF_STATUS = 8'h0c;
  localparam logic [7:0] ITC_OFF_CMPA = 8'h10;
  localparam logic [7:0] ITC_OFF_CMPB = 8'h14;
  localparam logic [7:0] ITC_OFF_READBACK = 8'h18;
  localparam logic [7:0] ITC_OFF_TEST = 8'h1c;
  localparam int ITC_CTL_COUNT_ENABLE = 0;
  localparam int ITC_CTL_CLOCK_SOURCE = 1;
  localparam int ITC_CTL_EDGE_SELECT = 2;
  localparam int ITC_CTL_DIVIDE_ENABLE = 3;
  localparam int ITC_CTL_MODE_LO = 4;
  localparam int ITC_CTL_MODE_HI = 5;
  localparam int ITC_MODE_IRQ_ENABLE = 0;
  localparam int ITC_MODE_ZERO_CLEAR = 1;
  localparam int ITC_STAT_INTERVAL = 0;
  localparam int ITC_TEST_PRESET = 0;
  localparam logic [1:0] ITC_TIMER_MODE_INTERVAL = 2'h0;
  localparam logic [23:0] ITC_CMPA_RESET = 24'hffffff;
  localparam logic [23:0] ITC_CMPB_RESET = 24'h0fffff;
  localparam logic [23:0] ITC_COUNT_RESET = 24'h000000;
  localparam logic [5:0] ITC_CONTROL_RESET = 6'h00;
  localparam logic [2:0] ITC_DIVIDER_RESET = 3'h0;
  localparam logic [7:0] ITC_PRESCALE_RESET = 8'h00;
endpackage

// file: rtl/itc_ext_sync.sv
// Three-stage synchroniser with agreement filter and edge detection for the external clock.
`timescale 1ns/1ps
module itc_ext_sync (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic ext_in, // External clock pin.
  input wire logic falling_sel, // High selects the falling edge.
  output logic edge_pulse // One-cycle pulse on the chosen edge.
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  logic agree;

  assign agree = (s2_reg == s3_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= ext_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg <= 1'b0;
    end else if (agree) begin
      level_reg <= s3_reg;
    end
  end

  // The edge counts once the filtered level changes.
  assign edge_pulse = agree && (s3_reg != level_reg) && (s3_reg == !falling_sel);
endmodule // itc_ext_sync

// file: rtl/itc_prescaler.sv
// Power-of-two prescaler that turns source ticks into count enables.
`timescale 1ns/1ps
module itc_prescaler (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic tick_in, // Source tick, one cycle.
  input wire logic divide_en, // High enables division.
  input wire logic [2:0] divide_code, // Division code, ratio 2 to the code plus one.
  input wire logic clear, // Restarts the prescaler.
  output logic tick_out // Divided tick, one cycle.
);
  import itc_pkg::*;
  logic [7:0] cnt_reg;
  logic [7:0] limit;

  // Code n divides by 2**(n+1), so the counter wraps at that value minus one.
  assign limit = 8'(({1'b0, 8'h01} << (4'(divide_code) + 4'h1)) - 9'h001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= ITC_PRESCALE_RESET;
    end else if (clear || !divide_en) begin
      cnt_reg <= ITC_PRESCALE_RESET;
    end else if (tick_in) begin
      cnt_reg <= (cnt_reg >= limit) ? ITC_PRESCALE_RESET : cnt_reg + 8'h01;
    end
  end

  assign tick_out = divide_en ? (tick_in && cnt_reg >= limit) : tick_in;
endmodule // itc_prescaler

// file: rtl/itc_timer.sv
// Interval timer/counter with APB register slave.
// Behaviour
// - Match A while counting sets flag, requests, only when request enable is set
// - Writing zero clears flag; one ignored
// - Compare A read/write, resets to ones
// - Compare B read/write, printed reset value
// - Readback shows live count, top reserved
// - Preset control allows writing the count
// - Reserved bits read zero, writes dropped
// - Interval mode when mode field is 00
// - Source select: system clock or external
// - Divide enable divides by 2 to 256
// - Edge select picks external counting edge
// - Count enable starts counter incrementing
// - Request is flag gated by enable, inverted
// - Zero clear restarts counter at match
// - Without zero clear counter halts at match
// - Single request, periodic if zero clear set
// - Enable low never asserts a request
// - System clock counts on rising edge
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module itc_timer (
  input wire logic pclk, // System clock, 100 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB byte strobes.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped addresses.
  input wire logic ext_clk_in, // External count clock pin.
  output logic timer_irq_n // Timer interrupt request, active low.
);
  import itc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [5:0] timer_control_reg;
  logic [2:0] clock_divider_reg;
  logic [1:0] interval_mode_reg;
  logic interval_status_flag_reg;
  logic [23:0] compare_value_a_reg;
  logic [23:0] compare_value_b_reg;
  logic [23:0] count_reg;
  logic preset_test_control_reg;
  logic halted_reg;
  logic [31:0] prdata_reg;

  logic wr;
  logic rd;
  logic mapped;
  logic [31:0] wmask;
  logic count_enable;
  logic clock_source_select;
  logic ext_edge_select;
  logic clock_divide_enable;
  logic [1:0] timer_mode_field;
  logic interval_irq_enable;
  logic zero_clear_enable;
  logic ext_tick;
  logic src_tick;
  logic count_tick;
  logic match_a;
  logic count_write;
  logic flag_clear;

  ////////////////////////////////////////////////////////////////////////////
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= ITC_OFF_TEST);
  assign pslverr = psel && penable && !mapped;
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  assign count_enable = timer_control_reg[ITC_CTL_COUNT_ENABLE];
  assign clock_source_select = timer_control_reg[ITC_CTL_CLOCK_SOURCE];
  assign ext_edge_select = timer_control_reg[ITC_CTL_EDGE_SELECT];
  assign clock_divide_enable = timer_control_reg[ITC_CTL_DIVIDE_ENABLE];
  assign timer_mode_field = timer_control_reg[ITC_CTL_MODE_HI:ITC_CTL_MODE_LO];
  assign interval_irq_enable = interval_mode_reg[ITC_MODE_IRQ_ENABLE];
  assign zero_clear_enable = interval_mode_reg[ITC_MODE_ZERO_CLEAR];

  ////////////////////////////////////////////////////////////////////////////
  // Count source and prescaler.
  itc_ext_sync u_ext_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ext_in(ext_clk_in),
    .falling_sel(ext_edge_select),
    .edge_pulse(ext_tick)
  );

  // The internal source ticks every rising pclk edge.
  assign src_tick = clock_source_select ? ext_tick : 1'b1;

  itc_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(src_tick),
    .divide_en(clock_divide_enable),
    .divide_code(clock_divider_reg),
    .clear(!count_enable),
    .tick_out(count_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter.
  assign match_a = count_enable && (timer_mode_field == ITC_TIMER_MODE_INTERVAL)
                   && (count_reg == compare_value_a_reg) && !halted_reg;
  assign count_write = wr && (paddr == ITC_OFF_READBACK) && preset_test_control_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= ITC_COUNT_RESET;
    end else if (count_write) begin
      count_reg <= (count_reg & ~wmask[23:0]) | (pwdata[23:0] & wmask[23:0]);
    end else if (match_a && zero_clear_enable && count_tick) begin
      count_reg <= ITC_COUNT_RESET;
    end else if (count_enable && count_tick && !match_a && !halted_reg) begin
      count_reg <= count_reg + 24'h000001;
    end
  end

  // Without zero clear the counter stops at the match until restarted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halted_reg <= 1'b0;
    end else if (!count_enable || count_write || (halted_reg && zero_clear_enable)) begin
      halted_reg <= 1'b0;
    end else if (match_a && !zero_clear_enable) begin
      halted_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interval status flag, set on a new match, set wins over clear.
  assign flag_clear = wr && (paddr == ITC_OFF_STATUS) && pstrb[0] && !pwdata[ITC_STAT_INTERVAL];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_status_flag_reg <= 1'b0;
    end else if (match_a && interval_irq_enable && !halted_reg && (count_tick || !zero_clear_enable)) begin
      interval_status_flag_reg <= 1'b1;
    end else if (flag_clear) begin
      interval_status_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq_n <= 1'b1;
    end else begin
      timer_irq_n <= !(interval_status_flag_reg && interval_irq_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; reserved bits are simply not stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control_reg <= ITC_CONTROL_RESET;
    end else if (wr && paddr == ITC_OFF_CONTROL && pstrb[0]) begin
      timer_control_reg <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_divider_reg <= ITC_DIVIDER_RESET;
    end else if (wr && paddr == ITC_OFF_DIVIDER && pstrb[0]) begin
      clock_divider_reg <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_mode_reg <= 2'h0;
    end else if (wr && paddr == ITC_OFF_MODE && pstrb[0]) begin
      interval_mode_reg <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preset_test_control_reg <= 1'b0;
    end else if (wr && paddr == ITC_OFF_TEST && pstrb[0]) begin
      preset_test_control_reg <= pwdata[ITC_TEST_PRESET];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_value_a_reg <= ITC_CMPA_RESET;
    end else if (wr && paddr == ITC_OFF_CMPA) begin
      compare_value_a_reg <= (compare_value_a_reg & ~wmask[23:0]) | (pwdata[23:0] & wmask[23:0]);
    end
  end

  // Software is expected to keep this above compare A; nothing here enforces it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_value_b_reg <= ITC_CMPB_RESET;
    end else if (wr && paddr == ITC_OFF_CMPB) begin
      compare_value_b_reg <= (compare_value_b_reg & ~wmask[23:0]) | (pwdata[23:0] & wmask[23:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered at the setup cycle so it is valid in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        ITC_OFF_CONTROL: prdata_reg <= {26'h0000000, timer_control_reg};
        ITC_OFF_DIVIDER: prdata_reg <= {29'h00000000, clock_divider_reg};
        ITC_OFF_MODE: prdata_reg <= {30'h00000000, interval_mode_reg};
        ITC_OFF_STATUS: prdata_reg <= {31'h00000000, interval_status_flag_reg};
        ITC_OFF_CMPA: prdata_reg <= {8'h00, compare_value_a_reg};
        ITC_OFF_CMPB: prdata_reg <= {8'h00, compare_value_b_reg};
        ITC_OFF_READBACK: prdata_reg <= {8'h00, count_reg};
        ITC_OFF_TEST: prdata_reg <= {31'h00000000, preset_test_control_reg};
        default: prdata_reg <= 32'h00000000;
      endcase
    end
  end

  assign prdata = rd ? prdata_reg : 32'h00000000;
endmodule // itc_timer

// file: testbench/itc_timer_sva.sv
// Concurrent assertions on the interval timer's bus and request pins.
`timescale 1ns/1ps
module itc_timer_sva (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pwrite, // Direction.
  input wire logic [7:0] paddr, // Address.
  input wire logic [31:0] pwdata, // Write data.
  input wire logic [3:0] pstrb, // Strobes.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic ext_clk_in, // External clock.
  input wire logic timer_irq_n // Request, active low.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic rd_acc;
  assign acc = psel && penable;
  assign rd_acc = acc && !pwrite;
  chk_ready_high: assert property (psel |-> pready) else $error("pready low in a transfer.");
  chk_err_decode: assert property (acc |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h1c))
    else $error("pslverr does not match the address decode.");
  chk_err_zero: assert property (rd_acc && pslverr |-> prdata == 32'h0) else $error("Refused read not zero.");
  chk_idle_zero: assert property (!rd_acc |-> prdata == 32'h0) else $error("prdata not zero outside a read.");
  chk_status_reserved: assert property (rd_acc && paddr == 8'h0c |-> prdata[31:1] == 31'h0)
    else $error("Status reserved bits not zero.");
  chk_count_reserved: assert property (rd_acc && paddr == 8'h18 |-> prdata[31:24] == 8'h0)
    else $error("Readback reserved bits not zero.");
  chk_cmp_reserved: assert property (rd_acc && paddr inside {8'h10, 8'h14} |-> prdata[31:24] == 8'h0)
    else $error("Compare reserved bits not zero.");
  chk_ctl_reserved: assert property (rd_acc && paddr == 8'h00 |-> prdata[31:6] == 26'h0)
    else $error("Control reserved bits not zero.");
  chk_irq_mask: assert property (acc && pwrite && paddr == 8'h08 && pstrb[0] && !pwdata[0] |-> ##2 timer_irq_n)
    else $error("Request not masked after enable cleared.");
  cover property (!timer_irq_n);
  cover property ($rose(timer_irq_n));
  cover property (rd_acc && pslverr);
endmodule // itc_timer_sva
////////////////////////////////////////////////////////////////////////
bind itc_timer itc_timer_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ext_clk_in(ext_clk_in), .timer_irq_n(timer_irq_n));

// file: testbench/itc_timer_bench.sv
// Self-checking bench for the interval timer.
`timescale 1ns/1ps
module itc_timer_bench;
  import itc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic ext_clk_in = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic er;
  logic timer_irq_n;
  int num_errors = 0;
  int tests_run = 0;
  int n;
  always #5 pclk = ~pclk;
  itc_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clk_in(ext_clk_in), .timer_irq_n(timer_irq_n));
  ////////////////////////////////////////////////////////////////////////
  task automatic fail(input string m);
    num_errors++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) fail($sformatf("value %h, expected %h", g, e));
  endtask
  task automatic check_pin(input logic g, input logic e);
    tests_run++;
    if (g !== e) fail($sformatf("level %b, expected %b", g, e));
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check_val(rd, e);
  endtask
  // Stops counting, presets the count to zero, clears the flag and starts again.
  task automatic restart(input logic [31:0] cmpa, input logic [31:0] mode, input logic [31:0] ctl);
    wr(ITC_OFF_CONTROL, 32'h0);
    wr(ITC_OFF_TEST, 32'h1);
    wr(ITC_OFF_READBACK, 32'h0);
    wr(ITC_OFF_TEST, 32'h0);
    wr(ITC_OFF_MODE, mode);
    wr(ITC_OFF_STATUS, 32'h0);
    wr(ITC_OFF_CMPA, cmpa);
    wr(ITC_OFF_CONTROL, ctl);
  endtask
  task automatic wait_irq(input logic lvl, input int lim, output int c);
    c = 0;
    while (timer_irq_n !== lvl && c < lim) begin
      @(posedge pclk);
      c++;
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    fail("watchdog expired");
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(ITC_OFF_CMPA, 32'h00ffffff);
    rd_chk(ITC_OFF_CMPB, 32'h000fffff);
    rd_chk(ITC_OFF_READBACK, 32'h0);
    check_pin(timer_irq_n, 1'b1);
    $display("test reset values done");
    wr(ITC_OFF_CMPB, 32'h12345678);
    rd_chk(ITC_OFF_CMPB, 32'h00345678);
    wr(ITC_OFF_CMPA, 32'hffffffff);
    rd_chk(ITC_OFF_CMPA, 32'h00ffffff);
    wr(ITC_OFF_READBACK, 32'h55);
    rd_chk(ITC_OFF_READBACK, 32'h0);
    wr(ITC_OFF_TEST, 32'h1);
    wr(ITC_OFF_READBACK, 32'hab000055);
    rd_chk(ITC_OFF_READBACK, 32'h55);
    apb(1'b0, 8'h20, 32'h0);
    check_pin(er, 1'b1);
    check_val(rd, 32'h0);
    $display("test registers done");
    restart(32'd20, 32'h1, 32'h1);
    wait_irq(1'b0, 60, n);
    check_pin(timer_irq_n, 1'b0);
    check_pin(n inside {[18:26]}, 1'b1);
    rd_chk(ITC_OFF_STATUS, 32'h1);
    rd_chk(ITC_OFF_READBACK, 32'd20);
    wr(ITC_OFF_STATUS, 32'h1);
    check_pin(timer_irq_n, 1'b0);
    wr(ITC_OFF_STATUS, 32'h0);
    repeat (2) @(posedge pclk);
    check_pin(timer_irq_n, 1'b1);
    repeat (50) @(posedge pclk);
    check_pin(timer_irq_n, 1'b1);
    rd_chk(ITC_OFF_READBACK, 32'd20);
    $display("test one shot done");
    restart(32'd20, 32'h3, 32'h1);
    wait_irq(1'b0, 60, n);
    wr(ITC_OFF_STATUS, 32'h0);
    wait_irq(1'b1, 4, n);
    wait_irq(1'b0, 40, n);
    check_pin(timer_irq_n, 1'b0);
    apb(1'b0, ITC_OFF_READBACK, 32'h0);
    check_pin(rd <= 32'd20, 1'b1);
    wr(ITC_OFF_MODE, 32'h2);
    repeat (2) @(posedge pclk);
    check_pin(timer_irq_n, 1'b1);
    rd_chk(ITC_OFF_STATUS, 32'h1);
    wr(ITC_OFF_STATUS, 32'h0);
    repeat (60) @(posedge pclk);
    check_pin(timer_irq_n, 1'b1);
    rd_chk(ITC_OFF_STATUS, 32'h0);
    $display("test periodic and mask done");
    for (int k = 0; k < 8; k++) begin
      wr(ITC_OFF_DIVIDER, 32'(k));
      restart(32'h300000, 32'h0, 32'h9);
      repeat (512) @(posedge pclk);
      apb(1'b0, ITC_OFF_READBACK, 32'h0);
      check_pin(rd >= (512 >> (k + 1)) && rd <= (512 >> (k + 1)) + 2, 1'b1);
    end
    $display("test divider done");
    for (int e = 0; e < 2; e++) begin
      restart(32'h300000, 32'h0, 32'h3 | 32'(e << 2));
      repeat (10) begin
        repeat (4) @(posedge pclk);
        ext_clk_in <= 1'b1;
        repeat (4) @(posedge pclk);
        ext_clk_in <= 1'b0;
      end
      repeat (4) @(posedge pclk);
      ext_clk_in <= 1'b1;
      repeat (8) @(posedge pclk);
      rd_chk(ITC_OFF_READBACK, 32'd11 - 32'(e));
      ext_clk_in <= 1'b0;
    end
    $display("test external clock done");
    restart(32'd5, 32'h1, 32'h11);
    repeat (40) @(posedge pclk);
    check_pin(timer_irq_n, 1'b1);
    $display("test mode field done");
    tally_and_finish();
  end
endmodule // itc_timer_bench
